// [core/ssalu_params.svh]
// Contract
// - signed half saturate clamps to -32768 and 32767, else passes through.
// - unsigned half saturate writes 65535 above 65535, else low halfword.
// - short unsigned saturate writes 65535 into source if above, else keeps.
// - data select: first operand if condition nonzero, else alternative.
// - data select immediate alternative is sign-extended to 32 bits.
// - address select: first address if condition nonzero, else alternative.
// - inverted data select: first operand if condition zero, else other.
// - inverted address select: first address if condition zero, else other.
// - word shift count is signed bits 5:0; positive left, negative right.
// - word shift zero-fills both ways; right shift by 32 gives zero.
// - short word shift sign-extends a 4-bit count, writes back to source.
// - packed shifts act per lane, zero-fill, never spill into the next lane.
// - byte count from bits 3:0, halfword count from bits 4:0, sign-extended.
// - packed count of -8 bytes or -16 halfwords yields all-zero lanes.
// - compare result shifts into bit 0 above destination bits 30:0.
// - equality compare inserts one if equal; immediate sign-extended.
// - signed ge inserts one if first not smaller; immediate sign-extended.
// - unsigned ge compares unsigned, inserts one if first not smaller.
// - unsigned greater-or-equal zero-extends the nine-bit immediate.
// - less-than inserts one if smaller; immediate extended per signedness.
`ifndef SSALU_PARAMS_SVH
`define SSALU_PARAMS_SVH

`define SSALU_SAT_S16_MIN  32'hFFFF8000
`define SSALU_SAT_S16_MAX  32'h00007FFF
`define SSALU_SAT_U16_MAX  32'h0000FFFF
`define SSALU_WORD_CNT_W   6
`define SSALU_BYTE_CNT_W   4
`define SSALU_HALF_CNT_W   5
`define SSALU_IMM_W        9
`define SSALU_IMM4_W       4
`define SSALU_RES_RESET    32'h00000000

`endif

// [core/ssalu_pkg.sv]
package ssalu_pkg;

    // operation codes, one-hot so the decoder can drive them directly
    typedef enum logic [12:0]
    {
        SSALU_OP_SAT_SIGNED_HALF   = 13'h0001,
        SSALU_OP_SAT_UNSIGNED_HALF = 13'h0002,
        SSALU_OP_SEL_DATA          = 13'h0004,
        SSALU_OP_SELN_DATA         = 13'h0008,
        SSALU_OP_SEL_ADDR          = 13'h0010,
        SSALU_OP_SELN_ADDR         = 13'h0020,
        SSALU_OP_WORD_SHIFT        = 13'h0040,
        SSALU_OP_BYTE_SHIFT        = 13'h0080,
        SSALU_OP_HALF_SHIFT        = 13'h0100,
        SSALU_OP_CMP_EQ            = 13'h0200,
        SSALU_OP_CMP_GE_S          = 13'h0400,
        SSALU_OP_CMP_GE_U          = 13'h0800,
        SSALU_OP_CMP_LT            = 13'h1000
    } ssalu_op_type;

    // issue bundle from the decoder and register file
    typedef struct packed
    {
        logic         valid;
        ssalu_op_type op;
        logic         useImm;     // second operand is the nine-bit immediate
        logic         shortForm;  // two-operand short encoding
        logic         ltUnsigned; // selects unsigned less-than
        logic [8:0]   immNineBit;
        logic [3:0]   immFourBit;
        logic [31:0]  srcA;       // data or address source
        logic [31:0]  srcB;
        logic [31:0]  condData;   // condition data register value
        logic [31:0]  destOld;    // destination value for accumulation
        logic [4:0]   destIdx;
        logic         destIsAddr;
    } ssalu_issue_type;

    // write-back bundle to the register file
    typedef struct packed
    {
        logic        valid;
        logic [4:0]  destIdx;
        logic        destIsAddr;
        logic [31:0] data;
    } ssalu_wb_type;

endpackage

// [core/ssalu_lane_shift.sv]
`include "ssalu_params.svh"

// zero-fill logical shift of one lane by a signed count
module ssalu_lane_shift #(
    parameter int LANE_W = 8,
    parameter int CNT_W  = 4
) (
    input  wire logic [LANE_W-1:0] laneIn,
    input  wire logic [CNT_W-1:0]  count,
    output logic      [LANE_W-1:0] laneOut
);
    logic [CNT_W-1:0] magnitude;

    // magnitude of a negative count; -2^(n-1) wraps to itself, which equals
    // the lane width for packed forms and 32 for the word form
    assign magnitude = count[CNT_W-1] ? CNT_W'(~count + 1'b1) : count;

    // shifting by the full lane width drops every bit, so no wrap into lane
    always_comb
    begin
        if (count[CNT_W-1])
            laneOut = laneIn >> magnitude;
        else
            laneOut = laneIn << magnitude;
    end
endmodule

// [core/ssalu_core.sv]
`include "ssalu_params.svh"

// saturate, select, logical shift and compare-accumulate slice.
// one operation issued per cycle, result registered one cycle later.
// the slice has no status output at all, so flags are never touched.
module ssalu_core (
    input  wire logic                       clk_sys,
    input  wire logic                       resetn,
    input  wire ssalu_pkg::ssalu_issue_type issue,
    output ssalu_pkg::ssalu_wb_type         wb
);

    ////////////////////////////////////////////////////////////////////////
    // operand preparation

    logic [31:0] immSext;
    logic [31:0] immZext;
    logic [31:0] operandB;
    logic [31:0] operandBUns;

    // nine-bit immediate, both extensions kept for the compare flavours
    assign immSext = {{23{issue.immNineBit[8]}}, issue.immNineBit};
    assign immZext = {23'h000000, issue.immNineBit};
    assign operandB = issue.useImm ? immSext : issue.srcB;
    assign operandBUns = issue.useImm ? immZext : issue.srcB;

    ////////////////////////////////////////////////////////////////////////
    // saturation

    logic [31:0] satSigned;
    logic [31:0] satUnsigned;

    // signed compare against the halfword limits
    always_comb
    begin
        if ($signed(issue.srcA) < $signed(`SSALU_SAT_S16_MIN))
            satSigned = `SSALU_SAT_S16_MIN;
        else if ($signed(issue.srcA) > $signed(`SSALU_SAT_S16_MAX))
            satSigned = `SSALU_SAT_S16_MAX;
        else
            satSigned = issue.srcA;
    end

    // short form keeps the whole word; long form copies the low halfword
    always_comb
    begin
        if (issue.srcA > `SSALU_SAT_U16_MAX)
            satUnsigned = `SSALU_SAT_U16_MAX;
        else if (issue.shortForm)
            satUnsigned = issue.srcA;
        else
            satUnsigned = {16'h0000, issue.srcA[15:0]};
    end

    ////////////////////////////////////////////////////////////////////////
    // select

    logic        condNonZero;
    logic [31:0] selAlt;
    logic [31:0] selResult;

    // both data and address selects share one mux, only sense differs
    assign condNonZero = |issue.condData;
    assign selAlt = issue.useImm ? immSext : issue.srcB;

    always_comb
    begin
        case (issue.op)
            ssalu_pkg::SSALU_OP_SEL_DATA,
            ssalu_pkg::SSALU_OP_SEL_ADDR:
                selResult = condNonZero ? issue.srcA : selAlt;
            default:
                selResult = condNonZero ? selAlt : issue.srcA;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // word logical shift

    logic [`SSALU_WORD_CNT_W-1:0] wordCount;
    logic [31:0]                  wordShifted;

    // short form sign-extends the four-bit immediate; register and
    // nine-bit forms take the low six bits as a signed count
    always_comb
    begin
        if (issue.shortForm)
            wordCount = {{2{issue.immFourBit[3]}}, issue.immFourBit};
        else if (issue.useImm)
            wordCount = issue.immNineBit[5:0];
        else
            wordCount = issue.srcB[5:0];
    end

    ssalu_lane_shift #(
        .LANE_W (32),
        .CNT_W  (`SSALU_WORD_CNT_W)
    ) u_word_shift (
        .laneIn  (issue.srcA),
        .count   (wordCount),
        .laneOut (wordShifted)
    );

    ////////////////////////////////////////////////////////////////////////
    // packed shifts

    logic [31:0]                  countSrc;
    logic [`SSALU_BYTE_CNT_W-1:0] byteCount;
    logic [`SSALU_HALF_CNT_W-1:0] halfCount;
    logic [31:0]                  byteShifted;
    logic [31:0]                  halfShifted;

    // count comes from the register or the immediate low bits
    assign countSrc = issue.useImm ? immSext : issue.srcB;
    assign byteCount = countSrc[3:0];
    assign halfCount = countSrc[4:0];

    // each lane has its own shifter so nothing crosses a lane boundary
    genvar gb;
    generate
        for (gb = 0; gb < 4; gb++)
        begin : g_byte
            ssalu_lane_shift #(
                .LANE_W (8),
                .CNT_W  (`SSALU_BYTE_CNT_W)
            ) u_byte (
                .laneIn  (issue.srcA[gb*8 +: 8]),
                .count   (byteCount),
                .laneOut (byteShifted[gb*8 +: 8])
            );
        end
        for (gb = 0; gb < 2; gb++)
        begin : g_half
            ssalu_lane_shift #(
                .LANE_W (16),
                .CNT_W  (`SSALU_HALF_CNT_W)
            ) u_half (
                .laneIn  (issue.srcA[gb*16 +: 16]),
                .count   (halfCount),
                .laneOut (halfShifted[gb*16 +: 16])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // compare and accumulate

    logic cmpBit;

    // one comparison bit per operation, extension chosen above
    always_comb
    begin
        case (issue.op)
            ssalu_pkg::SSALU_OP_CMP_EQ:
                cmpBit = (issue.srcA == operandB);
            ssalu_pkg::SSALU_OP_CMP_GE_S:
                cmpBit = ($signed(issue.srcA) >= $signed(operandB));
            ssalu_pkg::SSALU_OP_CMP_GE_U:
                cmpBit = (issue.srcA >= operandBUns);
            ssalu_pkg::SSALU_OP_CMP_LT:
                cmpBit = issue.ltUnsigned
                    ? (issue.srcA < operandBUns)
                    : ($signed(issue.srcA) < $signed(operandB));
            default:
                cmpBit = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // result mux

    logic [31:0] result;
    logic [4:0]  destIdx;

    always_comb
    begin
        case (issue.op)
            ssalu_pkg::SSALU_OP_SAT_SIGNED_HALF:
                result = satSigned;
            ssalu_pkg::SSALU_OP_SAT_UNSIGNED_HALF:
                result = satUnsigned;
            ssalu_pkg::SSALU_OP_SEL_DATA,
            ssalu_pkg::SSALU_OP_SELN_DATA,
            ssalu_pkg::SSALU_OP_SEL_ADDR,
            ssalu_pkg::SSALU_OP_SELN_ADDR:
                result = selResult;
            ssalu_pkg::SSALU_OP_WORD_SHIFT:
                result = wordShifted;
            ssalu_pkg::SSALU_OP_BYTE_SHIFT:
                result = byteShifted;
            ssalu_pkg::SSALU_OP_HALF_SHIFT:
                result = halfShifted;
            ssalu_pkg::SSALU_OP_CMP_EQ,
            ssalu_pkg::SSALU_OP_CMP_GE_S,
            ssalu_pkg::SSALU_OP_CMP_GE_U,
            ssalu_pkg::SSALU_OP_CMP_LT:
                result = {issue.destOld[30:0], cmpBit};
            default:
                result = `SSALU_RES_RESET;
        endcase
    end

    // short forms write back into the source register, whose index the
    // decoder places in destIdx; no separate source index is needed
    assign destIdx = issue.destIdx;

    ////////////////////////////////////////////////////////////////////////
    // write-back register

    logic         wbValid_r;
    logic [4:0]   wbIdx_r;
    logic         wbIsAddr_r;
    logic [31:0]  wbData_r;

    // valid cleared under reset so no spurious write reaches the file
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
            wbValid_r <= 1'b0;
        else
            wbValid_r <= issue.valid;
    end

    // payload registers; data only matters while valid is high
    always_ff @(posedge clk_sys)
    begin
        if (!resetn)
        begin
            wbIdx_r    <= 5'h00;
            wbIsAddr_r <= 1'b0;
            wbData_r   <= `SSALU_RES_RESET;
        end
        else if (issue.valid)
        begin
            wbIdx_r    <= destIdx;
            wbIsAddr_r <= issue.destIsAddr;
            wbData_r   <= result;
        end
    end

    // only the destination register is written; no flag path exists
    // one driver for the whole bundle, field order as the package declares
    assign wb = {wbValid_r, wbIdx_r, wbIsAddr_r, wbData_r};

endmodule

// [bench/ssalu_core_assertions.sv]
// port-level checker for the slice, bound to every ssalu_core
module ssalu_core_assertions (
    input wire logic                       clk_sys,
    input wire logic                       resetn,
    input wire ssalu_pkg::ssalu_issue_type issue,
    input wire ssalu_pkg::ssalu_wb_type    wb
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        go;
    logic [12:0] op;
    // qualified op keeps the properties short
    assign go = issue.valid;
    assign op = issue.op & {13{issue.valid}};
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////
    property p_one;
        go |=> wb.valid && wb.destIdx == $past(issue.destIdx);
    endproperty
    a_one: assert property (p_one) else $error("missing result");
    // an idle cycle must not disturb the held result
    property p_gap;
        !go |=> !wb.valid && $stable(wb.data);
    endproperty
    a_gap: assert property (p_gap) else $error("spurious result");
    property p_satu;
        op == 13'h0002 && issue.srcA > 32'h0000FFFF
        |=> wb.data == 32'h0000FFFF;
    endproperty
    a_satu: assert property (p_satu) else $error("no clamp");
    property p_sel;
        op == 13'h0004 && !issue.useImm |=> wb.data ==
        ($past(issue.condData) != '0 ? $past(issue.srcA) : $past(issue.srcB));
    endproperty
    a_sel: assert property (p_sel) else $error("bad select");
    property p_seln;
        op == 13'h0008 && !issue.useImm |=> wb.data ==
        ($past(issue.condData) == '0 ? $past(issue.srcA) : $past(issue.srcB));
    endproperty
    a_seln: assert property (p_seln) else $error("bad select");
    property p_sh32;
        op == 13'h0040 && !issue.shortForm && !issue.useImm
        && issue.srcB[5:0] == 6'h20 |=> wb.data == '0;
    endproperty
    a_sh32: assert property (p_sh32) else $error("bad shift");
    property p_pz;
        !issue.useImm && (op == 13'h0080 && issue.srcB[3:0] == 4'h8
        || op == 13'h0100 && issue.srcB[4:0] == 5'h10) |=> wb.data == '0;
    endproperty
    a_pz: assert property (p_pz) else $error("lane not zero");
    property p_eq;
        op == 13'h0200 && !issue.useImm |=> wb.data[0] ==
        ($past(issue.srcA) == $past(issue.srcB));
    endproperty
    a_eq: assert property (p_eq) else $error("bad compare");
    c_b2b: cover property (go [*3]);
    c_clamp: cover property (op == 13'h0002 ##1 wb.data == 32'h0000FFFF);
    c_eq: cover property (op == 13'h0200 ##1 wb.data[0]);
endmodule

bind ssalu_core ssalu_core_assertions u_ssalu_core_assertions (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .issue   (issue),
    .wb      (wb)
);

// [bench/ssalu_regfile_model.sv]
// data register file on the far side, fed by write-back
module ssalu_regfile_model (
    input wire logic                    clk_sys,
    input wire logic                    resetn,
    input wire ssalu_pkg::ssalu_wb_type wb,
    input wire logic [4:0]              rdIdx,
    output logic [31:0]                 rdData
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] file_r [32];
    // no forwarding: a read sees a write one edge after wb.valid
    always_ff @(posedge clk_sys)
    begin
        if (resetn && wb.valid && !wb.destIsAddr)
            file_r[wb.destIdx] <= wb.data;
    end
    assign rdData = file_r[rdIdx];
endmodule

// [bench/tb.sv]
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       clk_sys = 1'b0;
    logic                       resetn = 1'b0;
    ssalu_pkg::ssalu_issue_type issue = '0;
    ssalu_pkg::ssalu_wb_type    wb;
    ssalu_pkg::ssalu_issue_type x;
    logic [31:0]                rfData;
    logic [31:0]                expData = '0;
    logic [5:0]                 expIdx = '0;
    logic                       expValid = 1'b0;
    logic [191:0]               rnd;
    int                         n_mismatch = 0;
    int                         checks = 0;
    always #5 clk_sys = ~clk_sys;
    ssalu_core u_ssalu_core (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .issue   (issue),
        .wb      (wb)
    );
    ssalu_regfile_model u_ssalu_regfile_model (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .wb      (wb),
        .rdIdx   (5'h03),
        .rdData  (rfData)
    );
    ////////////////////////////////////////
    // lane-wise zero-fill shift; a 32-bit lane gives the word shift
    function automatic logic [31:0] lanes(logic [31:0] v, int w, int c);
        logic [63:0] m;
        logic [63:0] l;
        logic [31:0] r;
        m = (64'h1 << w) - 64'h1;
        r = '0;
        for (int n = 0; n < 32; n += w)
        begin
            l = (64'(v) >> n) & m;
            l = (c >= 0) ? (l << c) : (l >> -c);
            r = r | 32'((l & m) << n);
        end
        return r;
    endfunction
    // reference result for one issue
    function automatic logic [31:0] mdl(ssalu_pkg::ssalu_issue_type i);
        logic [31:0] a;
        logic [31:0] b;
        logic [31:0] u;
        a = i.srcA;
        b = i.useImm ? {{23{i.immNineBit[8]}}, i.immNineBit} : i.srcB;
        u = i.useImm ? {23'h0, i.immNineBit} : i.srcB;
        case (i.op)
            13'h0001: return ($signed(a) < $signed(32'hFFFF8000)) ?
                32'hFFFF8000 : ($signed(a) > 32'sh7FFF) ? 32'h7FFF : a;
            13'h0002: return (a > 32'h0000FFFF) ? 32'h0000FFFF : a;
            13'h0004, 13'h0010: return (i.condData != '0) ? a : b;
            13'h0008, 13'h0020: return (i.condData == '0) ? a : b;
            13'h0040: return lanes(a, 32, i.shortForm ?
                int'($signed(i.immFourBit)) : int'($signed(b[5:0])));
            13'h0080: return lanes(a, 8, int'($signed(b[3:0])));
            13'h0100: return lanes(a, 16, int'($signed(b[4:0])));
            13'h0200: return {i.destOld[30:0], a == b};
            13'h0400: return {i.destOld[30:0], $signed(a) >= $signed(b)};
            13'h0800: return {i.destOld[30:0], a >= u};
            13'h1000: return {i.destOld[30:0],
                i.ltUnsigned ? a < u : $signed(a) < $signed(b)};
            default: return '0;
        endcase
    endfunction
    function automatic ssalu_pkg::ssalu_issue_type mk(logic [12:0] op,
        logic [31:0] a, logic [31:0] b, logic [31:0] c, logic [8:0] imm,
        logic [2:0] f);
        ssalu_pkg::ssalu_issue_type r;
        r = '0;
        r.valid = 1'b1;
        r.op = ssalu_pkg::ssalu_op_type'(op);
        {r.srcA, r.srcB, r.condData, r.destOld} = {a, b, c, c};
        {r.immNineBit, r.immFourBit, r.destIdx} = {imm, imm[3:0], 5'h03};
        {r.ltUnsigned, r.shortForm, r.useImm} = f;
        return r;
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // check the previous result, then apply the next issue
    task automatic step(ssalu_pkg::ssalu_issue_type i);
        @(negedge clk_sys);
        chk("valid", 32'(wb.valid), 32'(expValid));
        chk("data", wb.data, expData);
        chk("index", 32'({wb.destIsAddr, wb.destIdx}), 32'(expIdx));
        issue = i;
        expValid = i.valid && resetn;
        if (!resetn)
            {expData, expIdx} = '0;
        else if (i.valid)
            {expData, expIdx} = {mdl(i), i.destIsAddr, i.destIdx};
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    ////////////////////////////////////////
    // a hang would otherwise run the simulation forever
    initial
    begin
        #600000;
        n_mismatch++;
        end_of_test();
    end
    initial
    begin
        void'($urandom(32'h74CC));
        repeat (2) @(negedge clk_sys);
        resetn = 1'b1;
        step(mk(13'h2, 32'h00010000, '0, '0, '0, 3'h0));
        step(mk(13'h2, 32'h0001FFFF, '0, '0, '0, 3'h2));
        step(mk(13'h1, 32'hFFFF7FFF, '0, '0, '0, 3'h0));
        step(mk(13'h4, 32'h11, 32'h22, '0, 9'h1F0, 3'h1));
        step(mk(13'h10, 32'h11, 32'h22, 32'h1, '0, 3'h0));
        step(mk(13'h8, 32'h11, 32'h22, '0, '0, 3'h0));
        step(mk(13'h20, 32'h11, 32'h22, 32'h5, 9'h100, 3'h1));
        step(mk(13'h40, '1, 32'h20, '0, '0, 3'h0));
        step(mk(13'h40, 32'h1, '0, '0, 9'h01F, 3'h1));
        step(mk(13'h40, 32'h80000000, '0, '0, 9'h008, 3'h2));
        step(mk(13'h80, 32'h81818181, 32'h7, '0, '0, 3'h0));
        step(mk(13'h80, '1, 32'h8, '0, '0, 3'h0));
        step(mk(13'h100, '1, 32'h10, '0, '0, 3'h0));
        step(mk(13'h100, 32'h80018001, 32'h1F, '0, '0, 3'h0));
        step(mk(13'h200, '1, '0, 32'h80000001, 9'h1FF, 3'h1));
        step(mk(13'h400, '0, '0, 32'h1, 9'h1FF, 3'h1));
        step(mk(13'h800, 32'h1FF, '0, 32'h1, 9'h1FF, 3'h1));
        step(mk(13'h800, '1, 32'h1, 32'h1, '0, 3'h0));
        step(mk(13'h1000, '0, '1, '0, '0, 3'h4));
        step(mk(13'h1000, '0, '1, '0, '0, 3'h0));
        // random ops, with idle gaps and back-to-back issues
        repeat (400)
        begin
            rnd = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
            x = rnd[163:0];
            x.op = ssalu_pkg::ssalu_op_type'(13'h1 << ($urandom % 13));
            step(x);
        end
        // reset in mid-run drops the pending issue and clears the result
        resetn = 1'b0;
        {expValid, expData, expIdx} = '0;
        step(mk(13'h2, '1, '0, '0, '0, 3'h0));
        step('0);
        resetn = 1'b1;
        // accumulate through the register file, spaced for write-back
        repeat (4)
        begin
            step(mk(13'h800, 32'h5, 32'h4, rfData, '0, 3'h0));
            step('0);
            step('0);
        end
        end_of_test();
    end
endmodule
